// File: uab_pkg.sv
// Constants, register map and types for the autobaud and wake-on-break helper
package uab_pkg;

  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam int DIV_W  = 16;

  // Register offsets on the plain register port
  localparam logic [ADDR_W-1:0] REG_BAUD_CTRL = 3'h0;
  localparam logic [ADDR_W-1:0] REG_DIV_LOW   = 3'h1;
  localparam logic [ADDR_W-1:0] REG_DIV_HIGH  = 3'h2;
  localparam logic [ADDR_W-1:0] REG_RX_DATA   = 3'h3;
  localparam logic [ADDR_W-1:0] REG_STATUS    = 3'h4;

  // Reset and start values
  localparam logic [DATA_W-1:0] CTRL_RESET      = 8'h00;
  localparam logic [DIV_W-1:0]  DIV_RESET       = 16'h0000;
  localparam logic [DIV_W-1:0]  ABD_COUNT_START = 16'h0001;
  localparam logic [DIV_W-1:0]  ABD_COUNT_MAX   = 16'hffff;
  localparam logic [DATA_W-1:0] READ_ZERO       = 8'h00;

  // Clock and divider figures
  localparam int CLK_MHZ       = 25;
  localparam int BASE_DIV_SLOW = 64;
  localparam int BASE_DIV_MID  = 16;
  localparam int BASE_DIV_FAST = 4;
  localparam int ABD_RATIO     = 8;
  localparam int PRESC_W       = 9;

  // Rising edges of the sync character, stop bit edge included
  localparam int             EDGE_W        = 3;
  localparam logic [EDGE_W-1:0] EDGE_FIRST = 3'h1;
  localparam logic [EDGE_W-1:0] EDGE_LAST  = 3'h5;
  localparam logic [EDGE_W-1:0] EDGE_ZERO  = 3'h0;

  // Baud control register layout, bit 7 down to bit 0
  typedef struct packed {
    logic reserved;
    logic rx_idle;
    logic sync_mode;
    logic autobaud_overflow_flag;
    logic high_speed_divisor_select;
    logic sixteen_bit_divisor_select;
    logic wake_on_break_enable;
    logic autobaud_enable;
  } uab_ctrl_t;

  // Status register layout
  typedef struct packed {
    logic [6:0] reserved;
    logic       receive_interrupt_flag;
  } uab_status_t;

  typedef enum logic [3:0] {
    AB_IDLE  = 4'b0001,
    AB_START = 4'b0010,
    AB_FIRST = 4'b0100,
    AB_COUNT = 4'b1000
  } uab_abd_state_t;

endpackage

// File: uab_autobaud.sv
// Autobaud measurement and wake-on-break receive helper for the serial port
//
// Operation
// - Setting autobaud enable starts calibration; normal receiver is held idle throughout.
// - Calibration times a received 55h sync character with five rising edges.
// - Divisor counter starts counting at first rising edge after start bit.
// - Fifth rising edge: keep count, clear autobaud enable, set receive interrupt flag.
// - Reading receive data register clears the flag; software discards the value.
// - During calibration both divisor bytes form one 16-bit counter, any mode.
// - Calibration counter ticks at one eighth of the divisor base clock.
// - Calibration clock: both bits clear /512, one set /128, both set /32.
// - Counter starts at one; software subtracts one afterwards.
// - Overflow flag sets when counter passes 16 bits before fifth edge.
// - After overflow counting continues; fifth edge still sets flag, clears enable.
// - Overflow flag clears by software only once autobaud enable is clear.
// - With wake and autobaud enabled, calibrate the character after the break.
// - In sleep the port clocks stop; no baud ticks, no reception.
// - Wake enable, asynchronous mode only, holds the receiver idle watching for wake.
// - Falling receive line edge is the wake event; flag sets with it.
// - Wake flag sets synchronously awake, also while asleep; data read clears it.
// - Rising edge ending the break clears wake enable; receiver then idles.
// - Non-zero character under wake: start to first rise is the wake event.
//
// The strobed register port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps

module uab_autobaud
  import uab_pkg::*;
#(
  parameter int PRESCALE_W = PRESC_W
) (
  input  wire logic              CLK,
  input  wire logic              RSTN,
  input  wire logic [ADDR_W-1:0] ADDR,
  input  wire logic [DATA_W-1:0] WDATA,
  input  wire logic              WR,
  input  wire logic              RD,
  output logic      [DATA_W-1:0] RDATA,
  input  wire logic              RX_LINE,
  input  wire logic              SLEEP,
  input  wire logic [DATA_W-1:0] RX_DATA,
  input  wire logic              RX_DONE,
  input  wire logic              RX_BUSY,
  output logic                   RX_HOLD_IDLE,
  output logic      [DIV_W-1:0]  DIVISOR,
  output logic                   RECEIVE_INT
);

  // The slowest calibration divide needs nine prescaler bits
  if (PRESCALE_W < PRESC_W || PRESCALE_W > DIV_W) begin : g_bad_prescale
    $error("PRESCALE_W must hold a divide by 512");
  end

  uab_ctrl_t      ctrl;
  uab_status_t    status;
  uab_abd_state_t abd_state;
  uab_abd_state_t next_abd_state;
  logic [DIV_W-1:0]      divisor;
  logic [EDGE_W-1:0]     edge_count;
  logic [PRESCALE_W-1:0] presc;
  logic [PRESCALE_W-1:0] abd_term;
  logic                  receive_interrupt_flag;
  logic                  rx_meta;
  logic                  rx_sync;
  logic                  rx_prev;
  logic                  rx_fall;
  logic                  rx_rise;
  logic                  abd_tick;
  logic                  abd_done;
  logic                  abd_wrap;
  logic                  wake_active;
  logic                  wake_event;
  logic                  wake_end;
  logic                  ctrl_wr;
  logic                  rxdata_rd;
  uab_ctrl_t             wr_ctrl;
  logic                  autobaud_enable;
  logic                  wake_on_break_enable;
  logic                  autobaud_overflow_flag;
  logic                  sixteen_bit_divisor_select;
  logic                  high_speed_divisor_select;
  logic                  sync_mode;
  logic                  abd_abort;
  logic                  first_rise;
  logic [PRESCALE_W-1:0] tick_gap;
  logic                  gap_clean;

  localparam int FAST_TERM = BASE_DIV_FAST * ABD_RATIO - 1;

  assign wr_ctrl   = uab_ctrl_t'(WDATA);
  assign ctrl_wr   = WR && (ADDR == REG_BAUD_CTRL);
  assign rxdata_rd = RD && (ADDR == REG_RX_DATA);
  // Clearing the enable by software aborts at the same edge
  assign abd_abort  = ctrl_wr && !wr_ctrl.autobaud_enable;
  assign first_rise = (abd_state == AB_FIRST) && rx_rise;

  // Two flops on the pin; the edge detector compares the second with a third flop
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      rx_meta <= 1'b1;
      rx_sync <= 1'b1;
      rx_prev <= 1'b1;
    end else begin
      rx_meta <= RX_LINE;
      rx_sync <= rx_meta;
      rx_prev <= rx_sync;
    end
  end

  assign rx_fall = rx_prev && !rx_sync;
  assign rx_rise = !rx_prev && rx_sync;

  // Wake only acts in asynchronous mode
  assign wake_active = wake_on_break_enable && !sync_mode;
  // Any falling edge counts, so a non-zero character wakes on its start bit
  assign wake_event  = wake_active && rx_fall;
  assign wake_end    = wake_active && rx_rise;

  // Calibration clock: base clock divided by eight more
  always_comb begin
    case ({ctrl.sixteen_bit_divisor_select, ctrl.high_speed_divisor_select})
      2'b00:   abd_term = PRESCALE_W'(BASE_DIV_SLOW * ABD_RATIO - 1);
      2'b11:   abd_term = PRESCALE_W'(BASE_DIV_FAST * ABD_RATIO - 1);
      default: abd_term = PRESCALE_W'(BASE_DIV_MID * ABD_RATIO - 1);
    endcase
  end

  // Clocks to the port stop in sleep, so the prescaler freezes
  assign abd_tick = !SLEEP && (presc == abd_term);

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      presc <= '0;
    end else if (SLEEP) begin
      presc <= presc;
    end else if (abd_tick || (abd_state == AB_FIRST && rx_rise)) begin
      presc <= '0;
    end else begin
      presc <= presc + 1'b1;
    end
  end

  // A break under wake is not measured; calibration waits for wake to drop
  always_comb begin
    next_abd_state = abd_state;
    case (abd_state)
      AB_IDLE: begin
        if (ctrl.autobaud_enable && !ctrl.wake_on_break_enable && !SLEEP) begin
          next_abd_state = AB_START;
        end
      end
      AB_START: begin
        if (rx_fall) begin
          next_abd_state = AB_FIRST;
        end
      end
      AB_FIRST: begin
        if (rx_rise) begin
          next_abd_state = AB_COUNT;
        end
      end
      AB_COUNT: begin
        if (abd_done) begin
          next_abd_state = AB_IDLE;
        end
      end
      default: next_abd_state = AB_IDLE;
    endcase
    if (!ctrl.autobaud_enable || abd_abort) begin
      next_abd_state = AB_IDLE;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      abd_state <= AB_IDLE;
    end else begin
      abd_state <= next_abd_state;
    end
  end

  // Fifth rising edge of the sync character closes the measurement
  assign abd_done = (abd_state == AB_COUNT) && rx_rise
                    && (edge_count == EDGE_LAST - 1'b1);
  assign abd_wrap = (abd_state == AB_COUNT) && abd_tick && (divisor == ABD_COUNT_MAX);

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      edge_count <= EDGE_ZERO;
    end else if (abd_state == AB_FIRST && rx_rise) begin
      edge_count <= EDGE_FIRST;
    end else if (abd_state == AB_COUNT && rx_rise) begin
      edge_count <= edge_count + 1'b1;
    end else if (abd_state == AB_IDLE) begin
      edge_count <= EDGE_ZERO;
    end
  end

  // Both bytes count as one 16-bit word whatever the divisor mode
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      divisor <= DIV_RESET;
    end else if (abd_state == AB_FIRST && rx_rise) begin
      divisor <= ABD_COUNT_START;
    end else if (abd_state == AB_COUNT) begin
      if (abd_tick && !abd_done) begin
        divisor <= divisor + 1'b1;
      end
    end else if (WR && ADDR == REG_DIV_LOW && abd_state == AB_IDLE) begin
      divisor <= {divisor[DIV_W-1:DATA_W], WDATA};
    end else if (WR && ADDR == REG_DIV_HIGH && abd_state == AB_IDLE) begin
      divisor <= {WDATA, divisor[DATA_W-1:0]};
    end
  end

  // Autobaud enable: software sets, hardware clears at the end
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      autobaud_enable <= 1'b0;
    end else if (abd_done) begin
      autobaud_enable <= 1'b0;
    end else if (ctrl_wr) begin
      autobaud_enable <= wr_ctrl.autobaud_enable;
    end
  end

  // Wake enable: the end of the break wins over a write in the same cycle
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      wake_on_break_enable <= 1'b0;
    end else if (wake_end) begin
      wake_on_break_enable <= 1'b0;
    end else if (ctrl_wr) begin
      wake_on_break_enable <= wr_ctrl.wake_on_break_enable;
    end
  end

  // Overflow: set wins over clear; a clear is ignored while still enabled
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      autobaud_overflow_flag <= 1'b0;
    end else if (abd_wrap && !abd_done) begin
      autobaud_overflow_flag <= 1'b1;
    end else if (ctrl_wr && !wr_ctrl.autobaud_overflow_flag && !autobaud_enable) begin
      autobaud_overflow_flag <= 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      sixteen_bit_divisor_select <= 1'b0;
      high_speed_divisor_select  <= 1'b0;
      sync_mode                  <= 1'b0;
    end else if (ctrl_wr) begin
      sixteen_bit_divisor_select <= wr_ctrl.sixteen_bit_divisor_select;
      high_speed_divisor_select  <= wr_ctrl.high_speed_divisor_select;
      sync_mode                  <= wr_ctrl.sync_mode;
    end
  end

  // Control view: one flop per concern, so no bit has two drivers
  assign ctrl.reserved                   = 1'b0;
  assign ctrl.rx_idle                    = !RX_BUSY && !RX_HOLD_IDLE;
  assign ctrl.sync_mode                  = sync_mode;
  assign ctrl.autobaud_overflow_flag     = autobaud_overflow_flag;
  assign ctrl.high_speed_divisor_select  = high_speed_divisor_select;
  assign ctrl.sixteen_bit_divisor_select = sixteen_bit_divisor_select;
  assign ctrl.wake_on_break_enable       = wake_on_break_enable;
  assign ctrl.autobaud_enable            = autobaud_enable;

  // Receive flag: any set wins over the clearing read
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      receive_interrupt_flag <= 1'b0;
    end else if (abd_done || wake_event || RX_DONE) begin
      receive_interrupt_flag <= 1'b1;
    end else if (rxdata_rd) begin
      receive_interrupt_flag <= 1'b0;
    end
  end

  assign status.reserved               = '0;
  assign status.receive_interrupt_flag = receive_interrupt_flag;

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      RDATA <= READ_ZERO;
    end else if (RD) begin
      case (ADDR)
        REG_BAUD_CTRL: RDATA <= ctrl;
        REG_DIV_LOW:   RDATA <= divisor[DATA_W-1:0];
        REG_DIV_HIGH:  RDATA <= divisor[DIV_W-1:DATA_W];
        REG_RX_DATA:   RDATA <= RX_DATA;
        REG_STATUS:    RDATA <= status;
        default:       RDATA <= READ_ZERO;
      endcase
    end else begin
      RDATA <= READ_ZERO;
    end
  end

  // Normal receiver idles during calibration and while watching for wake
  assign RX_HOLD_IDLE = autobaud_enable || wake_active;
  assign DIVISOR      = divisor;
  assign RECEIVE_INT  = receive_interrupt_flag;

  // Check helper: clocks since the prescaler last restarted, frozen in sleep
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      tick_gap <= '0;
    end else if (SLEEP) begin
      tick_gap <= tick_gap;
    end else if (abd_tick || first_rise) begin
      tick_gap <= '0;
    end else begin
      tick_gap <= tick_gap + 1'b1;
    end
  end

  // A mode write may leave the prescaler past the new term; trust the gap after a restart
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      gap_clean <= 1'b0;
    end else if (ctrl_wr) begin
      gap_clean <= 1'b0;
    end else if (!SLEEP && (abd_tick || first_rise)) begin
      gap_clean <= 1'b1;
    end
  end

  a_hold_idle: assert property (@(posedge CLK) disable iff (!RSTN)
    (abd_state != AB_IDLE) |-> RX_HOLD_IDLE)
    else $error("receiver not held idle during calibration");

  a_count_start: assert property (@(posedge CLK) disable iff (!RSTN)
    (abd_state == AB_FIRST && rx_rise && ctrl.autobaud_enable && !ctrl_wr)
      |=> (DIVISOR == ABD_COUNT_START && abd_state == AB_COUNT))
    else $error("calibration count did not start at one");

  a_fifth_edge: assert property (@(posedge CLK) disable iff (!RSTN)
    abd_done |=> (!ctrl.autobaud_enable && RECEIVE_INT && abd_state == AB_IDLE
                  && $stable(DIVISOR)))
    else $error("fifth edge did not end calibration");

  a_edge_count: assert property (@(posedge CLK) disable iff (!RSTN)
    (abd_state == AB_COUNT) |-> (edge_count >= EDGE_FIRST && edge_count < EDGE_LAST))
    else $error("edge count out of range");

  a_read_clear: assert property (@(posedge CLK) disable iff (!RSTN)
    (rxdata_rd && !abd_done && !wake_event && !RX_DONE) |=> !RECEIVE_INT)
    else $error("receive data read did not clear flag");

  a_ovf_wrap: assert property (@(posedge CLK) disable iff (!RSTN)
    (abd_wrap && !abd_done)
      |=> (ctrl.autobaud_overflow_flag && DIVISOR == DIV_RESET))
    else $error("overflow not flagged or counter not wrapped");

  a_ovf_hold: assert property (@(posedge CLK) disable iff (!RSTN)
    (ctrl.autobaud_overflow_flag && ctrl.autobaud_enable) |=> ctrl.autobaud_overflow_flag)
    else $error("overflow cleared while autobaud still enabled");

  a_ovf_clear: assert property (@(posedge CLK) disable iff (!RSTN)
    (ctrl_wr && !wr_ctrl.autobaud_overflow_flag && !ctrl.autobaud_enable && !abd_wrap)
      |=> !ctrl.autobaud_overflow_flag)
    else $error("overflow flag not cleared by software");

  a_tick_rate: assert property (@(posedge CLK) disable iff (!RSTN)
    (gap_clean && ctrl.sixteen_bit_divisor_select && ctrl.high_speed_divisor_select
     && !SLEEP)
      |-> (abd_tick == (tick_gap == PRESCALE_W'(FAST_TERM))))
    else $error("fast calibration tick not every 32 clocks");

  a_div_locked: assert property (@(posedge CLK) disable iff (!RSTN)
    (abd_state != AB_IDLE && !first_rise && !abd_tick) |=> $stable(DIVISOR))
    else $error("divisor moved outside a calibration tick");

  a_sleep_still: assert property (@(posedge CLK) disable iff (!RSTN)
    SLEEP |-> (!abd_tick && $stable(DIVISOR) || $past(WR)))
    else $error("counter moved during sleep");

  a_wake_flag: assert property (@(posedge CLK) disable iff (!RSTN)
    wake_event |=> RECEIVE_INT ##0 RX_HOLD_IDLE || !ctrl.wake_on_break_enable)
    else $error("wake event did not raise flag");

  a_wake_end: assert property (@(posedge CLK) disable iff (!RSTN)
    wake_end |=> !ctrl.wake_on_break_enable)
    else $error("end of break did not clear wake enable");

  a_wake_wait: assert property (@(posedge CLK) disable iff (!RSTN)
    (ctrl.wake_on_break_enable && abd_state == AB_IDLE) |=> (abd_state == AB_IDLE))
    else $error("calibration started during a break");

endmodule

// File: uab_lin_tx.sv
// Remote asynchronous serial transmitter model driving the receive line
`timescale 1ns/10ps

module uab_lin_tx #(
  parameter int BIT_CLKS = 401
) (
  input  wire logic CLK,
  output logic      LINE
);
  // Line rests high between frames, as an idle serial line does
  initial LINE = 1'b1;

  task automatic hold(input logic v, input int nbits);
    LINE <= v;
    repeat (nbits * BIT_CLKS) @(posedge CLK);
  endtask

  // Start bit, eight data bits low bit first, stop bit
  task automatic send_byte(input logic [7:0] b);
    hold(1'b0, 1);
    for (int i = 0; i < 8; i++) begin
      hold(b[i], 1);
    end
    hold(1'b1, 2);
  endtask

  // All-zero wake character, then back to idle
  task automatic send_break(input int nbits);
    hold(1'b0, nbits);
    hold(1'b1, 2);
  endtask
endmodule

// File: uab_autobaud_test.sv
// Self-checking bench for the autobaud and wake-on-break helper
`timescale 1ns/10ps
`define CHK(a, e) \
  begin n_tests++; if ((a) !== (e)) begin n_fail++; \
  $display("mismatch %0t got %h exp %h", $time, (a), (e)); end end

module uab_autobaud_test
  import uab_pkg::*;
;
  // Odd bit length keeps the fifth edge clear of a prescaler tick
  localparam int BIT_CLKS = 401;

  logic              CLK, RSTN, WR, RD, SLEEP, RX_DONE, RX_BUSY;
  logic              RX_LINE, RX_HOLD_IDLE, RECEIVE_INT;
  logic [ADDR_W-1:0] ADDR;
  logic [DATA_W-1:0] WDATA, RDATA, RX_DATA, rd_val;
  logic [DIV_W-1:0]  DIVISOR;
  int                n_fail, n_tests;

  uab_autobaud uab_autobaud_inst (
    .CLK(CLK), .RSTN(RSTN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .RX_LINE(RX_LINE), .SLEEP(SLEEP), .RX_DATA(RX_DATA),
    .RX_DONE(RX_DONE), .RX_BUSY(RX_BUSY), .RX_HOLD_IDLE(RX_HOLD_IDLE),
    .DIVISOR(DIVISOR), .RECEIVE_INT(RECEIVE_INT)
  );

  uab_lin_tx #(.BIT_CLKS(BIT_CLKS)) uab_lin_tx_inst (.CLK(CLK), .LINE(RX_LINE));

  initial begin
    CLK = 1'b0;
    forever #20 CLK = ~CLK;
  end

  task automatic final_report();
    if (n_fail == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Bus tasks start just after an edge and leave one idle edge behind
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    ADDR  <= a;
    WDATA <= d;
    WR    <= 1'b1;
    @(posedge CLK);
    WR    <= 1'b0;
    @(posedge CLK);
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a);
    ADDR <= a;
    RD   <= 1'b1;
    @(posedge CLK);
    RD   <= 1'b0;
    #1 rd_val = RDATA;
    @(posedge CLK);
  endtask

  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    rd(a);
    `CHK(rd_val, e)
  endtask

  // Normal receiver hands over a byte with a one-cycle done pulse
  task automatic rx_deliver(input logic [DATA_W-1:0] b);
    RX_DATA <= b;
    RX_DONE <= 1'b1;
    @(posedge CLK);
    RX_DONE <= 1'b0;
    @(posedge CLK);
  endtask

  task automatic busy_chk(input logic busy, input logic [DATA_W-1:0] e);
    RX_BUSY <= busy;
    rd_chk(REG_BAUD_CTRL, e);
  endtask

  task automatic calibrate(input logic [1:0] sel, input logic [DIV_W-1:0] e);
    wr(REG_BAUD_CTRL, {4'h0, sel, 2'b01});
    `CHK(RX_HOLD_IDLE, 1'b1)
    uab_lin_tx_inst.send_byte(8'h55);
    `CHK(RECEIVE_INT, 1'b1)
    `CHK(DIVISOR, e)
    rd_chk(REG_BAUD_CTRL, {4'h4, sel, 2'b00});
    rd_chk(REG_DIV_HIGH, 8'h00);
    rd_chk(REG_DIV_LOW, e[7:0]);
    rd(REG_RX_DATA);
    `CHK(RECEIVE_INT, 1'b0)
  endtask

  initial begin
    int div;
    RSTN = 1'b0; WR = 1'b0; RD = 1'b0; SLEEP = 1'b0; RX_DONE = 1'b0;
    RX_BUSY = 1'b0; ADDR = '0; WDATA = '0; RX_DATA = 8'h00;
    n_fail = 0; n_tests = 0;
    repeat (16) @(posedge CLK);
    RSTN <= 1'b1;
    repeat (2) @(posedge CLK);
    rd_chk(REG_BAUD_CTRL, 8'h40);
    `CHK(DIVISOR, DIV_RESET)
    rd_chk(REG_STATUS, 8'h00);
    rd_chk(3'h5, READ_ZERO);
    busy_chk(1'b1, 8'h00);
    busy_chk(1'b0, 8'h40);
    rx_deliver(8'h3c);
    `CHK(RECEIVE_INT, 1'b1)
    rd_chk(REG_RX_DATA, 8'h3c);
    `CHK(RECEIVE_INT, 1'b0)
    rx_deliver(8'ha5);
    rd_chk(REG_RX_DATA, 8'ha5);
    `CHK(RECEIVE_INT, 1'b0)
    wr(REG_DIV_LOW, 8'h34);
    wr(REG_DIV_HIGH, 8'h12);
    `CHK(DIVISOR, 16'h1234)
    // A stale 1234h start would show in every count below
    for (int s = 0; s < 4; s++) begin
      div = (s == 0) ? 512 : (s == 3) ? 32 : 128;
      calibrate(2'(s), 16'(1 + 8 * BIT_CLKS / div));
    end
    SLEEP <= 1'b1;
    wr(REG_BAUD_CTRL, 8'h0d);
    uab_lin_tx_inst.send_byte(8'h55);
    `CHK(RECEIVE_INT, 1'b0)
    `CHK(DIVISOR, 16'(1 + 8 * BIT_CLKS / 32))
    wr(REG_BAUD_CTRL, 8'h02);
    `CHK(RX_HOLD_IDLE, 1'b1)
    fork
      uab_lin_tx_inst.send_break(13);
      begin
        repeat (BIT_CLKS) @(posedge CLK);
        `CHK(RECEIVE_INT, 1'b1)
        rd_chk(REG_BAUD_CTRL, 8'h02);
      end
    join
    rd_chk(REG_BAUD_CTRL, 8'h40);
    SLEEP <= 1'b0;
    rd(REG_RX_DATA);
    `CHK(RECEIVE_INT, 1'b0)
    wr(REG_BAUD_CTRL, 8'h22);
    uab_lin_tx_inst.send_byte(8'h55);
    `CHK(RECEIVE_INT, 1'b0)
    wr(REG_BAUD_CTRL, 8'h02);
    fork
      uab_lin_tx_inst.send_byte(8'h55);
      begin
        repeat (BIT_CLKS / 2) @(posedge CLK);
        `CHK(RECEIVE_INT, 1'b1)
      end
    join
    rd_chk(REG_BAUD_CTRL, 8'h40);
    rd(REG_RX_DATA);
    wr(REG_BAUD_CTRL, 8'h0f);
    fork
      uab_lin_tx_inst.send_break(13);
      begin
        repeat (BIT_CLKS) @(posedge CLK);
        rd(REG_RX_DATA);
      end
    join
    `CHK(RECEIVE_INT, 1'b0)
    uab_lin_tx_inst.send_byte(8'h55);
    `CHK(RECEIVE_INT, 1'b1)
    `CHK(DIVISOR, 16'(1 + 8 * BIT_CLKS / 32))
    rd_chk(REG_BAUD_CTRL, 8'h4c);
    // Reset in mid-run must drop the pending flag and the measured count
    RSTN <= 1'b0;
    repeat (16) @(posedge CLK);
    `CHK(RECEIVE_INT, 1'b0)
    `CHK(DIVISOR, DIV_RESET)
    RSTN <= 1'b1;
    @(posedge CLK);
    rd_chk(REG_BAUD_CTRL, 8'h40);
    rd_chk(REG_DIV_LOW, 8'h00);
    final_report();
  end

  // Whole sequence needs about 50000 cycles
  initial begin
    repeat (90000) @(posedge CLK);
    n_fail++;
    final_report();
  end
endmodule
